// file: verilog/rcd_pkg.sv
// Shared constants and types for the receive cell delineation block.
package rcd_pkg;
   // ---------------------------------------------------------------
   // Geometry
   // ---------------------------------------------------------------
   localparam int NLINK = 16;
   localparam int NPAIR = 8;
   localparam int OUT_W = 37;               // Link 4, header flag 1, data 32.
   localparam int FIFO_DEPTH = 16;
   // ---------------------------------------------------------------
   // Register word addresses
   // ---------------------------------------------------------------
   localparam logic [11:0] TXLEN_BASE = 12'h08B;
   localparam logic [11:0] RXCTL_BASE = 12'h0C0;
   localparam logic [11:0] LODTHR_OFS = 12'h0C8;
   localparam logic [11:0] DELIN_OFS  = 12'h0C9;
   localparam logic [11:0] GROUP_LEN  = 12'h008;
   // ---------------------------------------------------------------
   // Reset values and readable masks
   // ---------------------------------------------------------------
   localparam logic [15:0] TXLEN_RST  = 16'h0101;
   localparam logic [15:0] RXCTL_RST  = 16'h0C0C;
   localparam logic [15:0] LODTHR_RST = 16'h000C;
   localparam logic [15:0] DELIN_RST  = 16'h0067;
   localparam logic [15:0] TXLEN_MASK = 16'h0FFF;
   localparam logic [15:0] BYTE_MASK  = 16'h00FF;
   // ---------------------------------------------------------------
   // Field positions (per-link byte of the receive control word, delineation word)
   // ---------------------------------------------------------------
   localparam int F_CORR    = 0;
   localparam int F_NOCOSET = 1;
   localparam int F_DISC    = 2;
   localparam int F_IDLEF   = 3;
   localparam int F_CNTUSR  = 4;
   localparam int F_DESCR   = 5;
   localparam int HI_LSB    = 8;            // Link N+8 byte / nibble.
   localparam int DELTA_LSB = 4;
   localparam int LOSS_LSB  = 0;
   // ---------------------------------------------------------------
   // Cell format and coding
   // ---------------------------------------------------------------
   localparam logic [7:0]  HEC_POLY  = 8'h07;
   localparam logic [7:0]  HEC_COSET = 8'h55;
   localparam logic [8:0]  CELL_LAST = 9'h1A7;   // 424 bits minus one.
   localparam logic [8:0]  PAY_BITS  = 9'h180;   // 384 payload bits.
   localparam logic [31:0] IDLE_HDR  = 32'h00000001;
   localparam logic [31:0] UNAS_MASK = 32'hFFFFFFF1;
   // ---------------------------------------------------------------
   // Delineation states
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_HUNT    = 3'b001,
      ST_PRESYNC = 3'b010,
      ST_SYNC    = 3'b100
   } rcd_state_t;
   localparam logic [1:0] CODE_HUNT    = 2'b00;
   localparam logic [1:0] CODE_PRESYNC = 2'b01;
   localparam logic [1:0] CODE_SYNC    = 2'b10;
endpackage

// file: verilog/rcd_fifo_if.sv
// Valid/ready carrier between the lane arbiter and the cell FIFO.
`timescale 1ns/1ps
interface rcd_fifo_if #(parameter int W = 37);
   logic [W-1:0] wdata;
   logic         wvalid;
   logic         wready;
   logic [W-1:0] rdata;
   logic         rvalid;
   logic         rready;
   modport store (input wdata, wvalid, rready, output wready, rdata, rvalid);
   modport fill  (output wdata, wvalid, input wready);
   modport drain (input rdata, rvalid, output rready);
endinterface

// file: verilog/rcd_fifo.sv
// Synchronous FIFO holding delineated cell words.
`timescale 1ns/1ps
module rcd_fifo #(
   parameter int W     = 37,
   parameter int DEPTH = 16
) (
   input wire logic  clk,
   input wire logic  rst,
   rcd_fifo_if.store f
);
   localparam int AW = $clog2(DEPTH);

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
      $error("rcd_fifo depth must be a power of two of at least 2");
   end

   logic [W-1:0] mem [DEPTH];
   logic [AW:0]  wp_q;
   logic [AW:0]  rp_q;
   wire          full  = (wp_q[AW] != rp_q[AW]) &&
                         (wp_q[AW-1:0] == rp_q[AW-1:0]);
   wire          empty = (wp_q == rp_q);
   wire          push  = f.wvalid && !full;
   wire          pop   = f.rvalid && f.rready;

   // Full and empty come straight from the pointers, so they never lie.
   assign f.wready = !full;
   assign f.rvalid = !empty;
   assign f.rdata  = mem[rp_q[AW-1:0]];

   // Storage has no reset; only words below the write pointer are read.
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wp_q[AW-1:0]] <= f.wdata;
      end
   end

   // Pointer update.
   always_ff @(posedge clk) begin
      if (rst) begin
         wp_q <= '0;
         rp_q <= '0;
      end else begin
         wp_q <= wp_q + (AW+1)'(push);
         rp_q <= rp_q + (AW+1)'(pop);
      end
   end
endmodule

// file: verilog/rcd_top.sv
// Receive cell delineation, header checking and link configuration.
`timescale 1ns/1ps
//
// Operation
// - Each control word holds link N low byte, link N+8 high byte.
// - Transmit FIFO length: link N+8 bits 11:8, link N bits 3:0.
// - Descrambling on for N+8 by bit 13, for N by bit 5.
// - Count pulse marks user cells if mode one, else idle/unassigned.
// - Idle-filter bit drops idle and unassigned cells; bits 11 and 3.
// - Discard bit drops bad-HEC cells, else bad-HEC cells pass; bits 10, 2.
// - Coset-disable bit checks HEC without coset; bits 9 and 1.
// - Correction bit fixes single-bit header errors; bits 8 and 0.
// - Loss threshold is doubled, giving 0 to 510 cell periods.
// - Count cell periods out of lock; at threshold flag loss.
// - One threshold and one DELTA/LOCK_LOSS_COUNT word serve all sixteen links.
// - Provisional to locked after DELTA good headers; bits 7:4, default 6.
// - Locked to search after LOCK_LOSS_COUNT bad headers; bits 3:0, default 7.
// - Unused bits 15:8 and FIFO-length bits 15:12 read zero.
// - State code: search 00, provisional 01, locked 10.
// - Idle header is three zero octets then 00000001.
// - Unassigned header is three zero octets then 0000xxx0.
// - Per-link locked indication reflects the current state, unlatched.
module rcd_top
   import rcd_pkg::*;
#(
   parameter int FIFO_W = OUT_W,
   parameter int FIFO_D = FIFO_DEPTH
) (
   input  wire logic        MCLK,
   input  wire logic        RESET,
   input  wire logic [11:0] CPU_ADDR,
   input  wire logic [15:0] CPU_WDATA,
   input  wire logic        CPU_WR,
   input  wire logic        CPU_RD,
   output logic      [15:0] CPU_RDATA,
   output logic             CPU_RVALID,
   input  wire logic [15:0] RX_BIT,
   input  wire logic [15:0] RX_TGL,
   output logic      [31:0] OUT_DATA,
   output logic      [3:0]  OUT_LINK,
   output logic             OUT_HDR,
   output logic             OUT_VALID,
   input  wire logic        OUT_READY,
   output logic      [63:0] TX_FIFO_LEN,
   output logic      [15:0] LINK_SYNC,
   output logic      [31:0] LINK_STATE,
   output logic      [15:0] DELINEATION_LOSS_THRESHOLD,
   output logic      [15:0] CELL_COUNT_PULSE
);
   if (FIFO_W != OUT_W) begin : g_bad_width
      $error("rcd_top FIFO width must match the cell word width");
   end

   // ---------------------------------------------------------------
   // HEC arithmetic
   // ---------------------------------------------------------------
   // Syndrome without coset: CRC-8 of the 32 header bits against HEC.
   function automatic logic [7:0] hec_lin(input logic [39:0] w);
      logic [7:0] c;
      c = 8'h00;
      for (int k = 39; k >= 8; k--) begin
         c = {c[6:0], 1'b0} ^ ((c[7] ^ w[k]) ? HEC_POLY : 8'h00);
      end
      return c ^ w[7:0];
   endfunction

   // Position plus one of the single bit matching a syndrome, else 0.
   function automatic logic [5:0] err_pos(input logic [7:0] s);
      logic [5:0] p;
      p = 6'h00;
      for (int j = 0; j < 40; j++) begin
         if (s != 8'h00 && hec_lin(40'h1 << j) == s) begin
            p = 6'(j + 1);
         end
      end
      return p;
   endfunction

   // ---------------------------------------------------------------
   // Register file
   // ---------------------------------------------------------------
   logic [15:0] txl_q [NPAIR];
   logic [15:0] ctl_q [NPAIR];
   logic [7:0]  thr_q;
   logic [7:0]  delin_q;

   wire [11:0] txl_off = CPU_ADDR - TXLEN_BASE;
   wire [11:0] ctl_off = CPU_ADDR - RXCTL_BASE;
   wire        txl_hit = CPU_ADDR >= TXLEN_BASE && txl_off < GROUP_LEN;
   wire        ctl_hit = CPU_ADDR >= RXCTL_BASE && ctl_off < GROUP_LEN;
   wire        thr_hit = CPU_ADDR == LODTHR_OFS;
   wire        del_hit = CPU_ADDR == DELIN_OFS;
   wire [2:0]  txl_idx = txl_off[2:0];
   wire [2:0]  ctl_idx = ctl_off[2:0];
   wire [3:0]  delta   = delin_q[DELTA_LSB +: 4];
   wire [3:0]  lock_loss_count   = delin_q[LOSS_LSB +: 4];
   wire [8:0]  lod_lim = {thr_q, 1'b0};

   // Read selection; unused upper bits and unmapped words read zero.
   wire [15:0] rd_mux =
      txl_hit ? (txl_q[txl_idx] & TXLEN_MASK) :
      ctl_hit ? ctl_q[ctl_idx] :
      thr_hit ? {8'h00, thr_q} :
      del_hit ? {8'h00, delin_q} :
      16'h0000;

   // Host writes; reserved control bits are stored as written.
   always_ff @(posedge MCLK) begin
      if (RESET) begin
         for (int p = 0; p < NPAIR; p++) begin
            txl_q[p] <= TXLEN_RST;
            ctl_q[p] <= RXCTL_RST;
         end
         thr_q   <= LODTHR_RST[7:0];
         delin_q <= DELIN_RST[7:0];
      end else if (CPU_WR) begin
         if (txl_hit) txl_q[txl_idx] <= CPU_WDATA & TXLEN_MASK;
         if (ctl_hit) ctl_q[ctl_idx] <= CPU_WDATA;
         if (thr_hit) thr_q <= CPU_WDATA[7:0];
         if (del_hit) delin_q <= CPU_WDATA[7:0];
      end
   end

   // Read data answers one clock after the read strobe.
   always_ff @(posedge MCLK) begin
      if (RESET) begin
         CPU_RDATA  <= 16'h0000;
         CPU_RVALID <= 1'b0;
      end else begin
         CPU_RDATA  <= CPU_RD ? rd_mux : 16'h0000;
         CPU_RVALID <= CPU_RD;
      end
   end

   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   logic [15:0] bit_s1_q;
   logic [15:0] bit_s2_q;
   logic [15:0] tgl_s1_q;
   logic [15:0] tgl_s2_q;
   logic [15:0] tgl_s3_q;

   // Edge detection reads only the second and third stages.
   always_ff @(posedge MCLK) begin
      if (RESET) begin
         bit_s1_q <= 16'h0000;
         bit_s2_q <= 16'h0000;
         tgl_s1_q <= 16'h0000;
         tgl_s2_q <= 16'h0000;
         tgl_s3_q <= 16'h0000;
      end else begin
         bit_s1_q <= RX_BIT;
         bit_s2_q <= bit_s1_q;
         tgl_s1_q <= RX_TGL;
         tgl_s2_q <= tgl_s1_q;
         tgl_s3_q <= tgl_s2_q;
      end
   end

   // ---------------------------------------------------------------
   // Per-link delineation lanes
   // ---------------------------------------------------------------
   logic [OUT_W-1:0] pend_w [NLINK];
   logic [15:0]      pv_w;
   logic [15:0]      gnt;

   for (genvar i = 0; i < NLINK; i++) begin : g_lane
      localparam int PAIR = i % NPAIR;
      localparam int BLSB = (i / NPAIR) * HI_LSB;
      wire [7:0]  cfg    = ctl_q[PAIR][BLSB +: 8];
      wire        ev     = tgl_s2_q[i] ^ tgl_s3_q[i];
      wire        nb     = bit_s2_q[i];
      rcd_state_t       st_q;
      logic [39:0]      win_q;
      logic [8:0]       cnt_q;
      logic [3:0]       run_q;
      logic [8:0]       lod_q;
      logic [42:0]      scr_q;
      logic [31:0]      acc_q;
      logic [4:0]       nacc_q;
      logic             keep_q;
      logic [OUT_W-1:0] pend_q;
      logic             pv_q;
      logic             cntp_q;
      logic             lodf_q;

      wire [39:0] nwin   = {win_q[38:0], nb};
      wire [7:0]  coset  = cfg[F_NOCOSET] ? 8'h00 : HEC_COSET;
      wire [7:0]  syn    = hec_lin(nwin) ^ coset;
      wire        hec_ok = syn == 8'h00;
      wire [5:0]  epos   = err_pos(syn);
      wire        fix    = cfg[F_CORR] && epos != 6'h00;
      wire [39:0] fixed  = fix ? nwin ^ (40'h1 << (epos - 6'h01)) : nwin;
      wire [31:0] hdr    = fixed[39:8];
      wire        idle   = hdr == IDLE_HDR;
      wire        unas   = (hdr & UNAS_MASK) == 32'h0;
      wire        filler = idle | unas;
      wire        good   = hec_ok | fix;
      wire        at_hdr = cnt_q == CELL_LAST;
      wire        in_pay = cnt_q < PAY_BITS;
      wire        drop   = (cfg[F_IDLEF] && filler) ||
                           (cfg[F_DISC] && !good);
      wire        keep   = st_q == ST_SYNC && !drop;
      wire        cnt_it = cfg[F_CNTUSR] ? !filler : filler;
      wire        pbit   = nb ^ (cfg[F_DESCR] & scr_q[42]);

      // Hunt, provisional and locked state walk; hunt tests every bit, the others one header per cell.
      always_ff @(posedge MCLK) begin
         if (RESET) begin
            st_q  <= ST_HUNT;
            run_q <= 4'h0;
            cnt_q <= 9'h000;
         end else if (ev) begin
            cnt_q <= at_hdr ? 9'h000 : cnt_q + 9'h001;
            unique case (st_q)
               ST_HUNT: begin
                  if (hec_ok) begin
                     st_q  <= ST_PRESYNC;
                     run_q <= 4'h0;
                     cnt_q <= 9'h000;
                  end
               end
               ST_PRESYNC: begin
                  if (at_hdr && !hec_ok) begin
                     st_q <= ST_HUNT;
                  end else if (at_hdr && run_q + 4'h1 >= delta) begin
                     st_q  <= ST_SYNC;
                     run_q <= 4'h0;
                  end else if (at_hdr) begin
                     run_q <= run_q + 4'h1;
                  end
               end
               ST_SYNC: begin
                  if (at_hdr && hec_ok) begin
                     run_q <= 4'h0;
                  end else if (at_hdr && run_q + 4'h1 >= lock_loss_count) begin
                     st_q  <= ST_HUNT;
                     run_q <= 4'h0;
                  end else if (at_hdr) begin
                     run_q <= run_q + 4'h1;
                  end
               end
            endcase
         end
      end

      // Header window, loss counter (quiet while locked) and descrambler.
      always_ff @(posedge MCLK) begin
         if (RESET) begin
            win_q  <= 40'h0;
            lod_q  <= 9'h000;
            scr_q  <= 43'h0;
            lodf_q <= 1'b0;
         end else begin
            lodf_q <= st_q != ST_SYNC && lod_q >= lod_lim;
            if (ev) begin
               win_q <= nwin;
               if (in_pay) scr_q <= {scr_q[41:0], nb};
               if (st_q == ST_SYNC) lod_q <= 9'h000;
               else if (at_hdr && lod_q != 9'h1FF)
                  lod_q <= lod_q + 9'h001;
            end
         end
      end

      // Cell word assembly; a fresh word wins over a same-cycle grant.
      always_ff @(posedge MCLK) begin
         if (RESET) begin
            keep_q <= 1'b0;
            acc_q  <= 32'h0;
            nacc_q <= 5'h00;
            pend_q <= '0;
            pv_q   <= 1'b0;
            cntp_q <= 1'b0;
         end else begin
            cntp_q <= ev && at_hdr && st_q == ST_SYNC && good && cnt_it;
            if (gnt[i]) pv_q <= 1'b0;
            if (ev && at_hdr && st_q != ST_HUNT) begin
               keep_q <= keep;
               nacc_q <= 5'h00;
               if (keep) begin
                  pend_q <= {4'(i), 1'b1, hdr};
                  pv_q   <= 1'b1;
               end
            end else if (ev && st_q == ST_HUNT) begin
               keep_q <= 1'b0;
            end else if (ev && in_pay && keep_q) begin
               acc_q  <= {acc_q[30:0], pbit};
               nacc_q <= nacc_q + 5'h01;
               if (nacc_q == 5'h1F) begin
                  pend_q <= {4'(i), 1'b0, acc_q[30:0], pbit};
                  pv_q   <= 1'b1;
               end
            end
         end
      end

      assign pend_w[i]              = pend_q;
      assign pv_w[i]                = pv_q;
      assign LINK_SYNC[i]           = st_q == ST_SYNC;
      assign LINK_STATE[2*i +: 2]   = st_q == ST_SYNC    ? CODE_SYNC :
                                      st_q == ST_PRESYNC ? CODE_PRESYNC :
                                      CODE_HUNT;
      assign DELINEATION_LOSS_THRESHOLD[i] = lodf_q;
      assign CELL_COUNT_PULSE[i]    = cntp_q;
      assign TX_FIFO_LEN[4*i +: 4]  = txl_q[PAIR][BLSB +: 4];
   end

   // ---------------------------------------------------------------
   // Lane arbiter and FIFO
   // ---------------------------------------------------------------
   // Fixed priority, lowest link first; a lane waits while the FIFO is
   // full and loses a word only if its next one completes meanwhile.
   rcd_fifo_if #(.W(OUT_W)) fq ();
   logic [3:0] sel;

   always_comb begin
      sel = 4'h0;
      for (int k = NLINK - 1; k >= 0; k--) begin
         if (pv_w[k]) sel = 4'(k);
      end
   end

   assign fq.wvalid = |pv_w;
   assign fq.wdata  = pend_w[sel];
   assign gnt       = (fq.wvalid && fq.wready) ? (16'h0001 << sel) : 16'h0;
   assign fq.rready = OUT_READY;
   assign OUT_VALID = fq.rvalid;
   assign OUT_LINK  = fq.rdata[36:33];
   assign OUT_HDR   = fq.rdata[32];
   assign OUT_DATA  = fq.rdata[31:0];

   rcd_fifo #(
      .W     (OUT_W),
      .DEPTH (FIFO_D)
   ) u_fifo (
      .clk (MCLK),
      .rst (RESET),
      .f   (fq.store)
   );
endmodule

// file: test/rcd_checker.sv
// Concurrent checks on the delineation block's top-level ports.
`timescale 1ns/1ps
module rcd_checker (
   input wire logic        MCLK,
   input wire logic        RESET,
   input wire logic [11:0] CPU_ADDR,
   input wire logic [15:0] CPU_WDATA,
   input wire logic        CPU_WR,
   input wire logic        CPU_RD,
   input wire logic [15:0] CPU_RDATA,
   input wire logic [63:0] TX_FIFO_LEN,
   input wire logic [15:0] LINK_SYNC,
   input wire logic [31:0] LINK_STATE,
   input wire logic [15:0] DELINEATION_LOSS_THRESHOLD,
   input wire logic [15:0] CELL_COUNT_PULSE
);
   logic [15:0] lk;
   logic [15:0] rsv;
   logic [15:0] wd_q;
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (RESET);
   // ---------------------------------------------------------------
   // Helper logic
   // ---------------------------------------------------------------
   // Per-link flags rebuilt from the two-bit state codes.
   always_comb begin
      for (int i = 0; i < 16; i++) begin
         lk[i] = LINK_STATE[2*i +: 2] == 2'b10;
         rsv[i] = LINK_STATE[2*i +: 2] == 2'b11;
      end
   end
   // Write data one cycle back, so a write's effect can be judged.
   always_ff @(posedge MCLK) begin
      wd_q <= CPU_WDATA;
   end
   property p_sync_eq; LINK_SYNC == lk; endproperty
   a_sync_eq: assert property (p_sync_eq)
      else $error("Lock flags differ from state codes.");
   property p_no_rsv; rsv == 16'h0000; endproperty
   a_no_rsv: assert property (p_no_rsv)
      else $error("Reserved state code seen.");
   property p_no_skip;
      LINK_STATE[1:0] == 2'b00 |=> LINK_STATE[1:0] != 2'b10;
   endproperty
   a_no_skip: assert property (p_no_skip)
      else $error("Search jumped straight to locked.");
   property p_lod_clr;
      LINK_SYNC[0] [*3] |-> !DELINEATION_LOSS_THRESHOLD[0];
   endproperty
   a_lod_clr: assert property (p_lod_clr)
      else $error("Loss flag raised while locked.");
   property p_pulse; CELL_COUNT_PULSE[0] |=> !CELL_COUNT_PULSE[0]; endproperty
   a_pulse: assert property (p_pulse)
      else $error("Count pulse longer than one cycle.");
   property p_txlen;
      CPU_WR && CPU_ADDR == 12'h08B |=> TX_FIFO_LEN[3:0] == wd_q[3:0]
         && TX_FIFO_LEN[35:32] == wd_q[11:8];
   endproperty
   a_txlen: assert property (p_txlen)
      else $error("FIFO length outputs not updated by write.");
   property p_thr_rd;
      CPU_RD && (CPU_ADDR == 12'h0C8 || CPU_ADDR == 12'h0C9)
         |=> CPU_RDATA[15:8] == 8'h00;
   endproperty
   a_thr_rd: assert property (p_thr_rd)
      else $error("Threshold upper byte not zero.");
   property p_len_rd;
      CPU_RD && CPU_ADDR >= 12'h08B && CPU_ADDR <= 12'h092
         |=> CPU_RDATA[15:12] == 4'h0;
   endproperty
   a_len_rd: assert property (p_len_rd)
      else $error("FIFO length upper nibble not zero.");
endmodule

// file: test/rcd_link_src.sv
// Serial framer model feeding link 0 with toggle-marked bits.
`timescale 1ns/1ps
module rcd_link_src (
   input  wire logic        clk,
   output logic      [15:0] rx_bit,
   output logic      [15:0] rx_tgl
);
   int k;
   // Idle lines: no toggles, so no bits are delivered.
   initial begin
      rx_bit = 16'h0000;
      rx_tgl = 16'h0000;
      k = 0;
   end
   // Data first, toggle an edge later, then a hold of three to five
   // edges, so the receiver sees both prompt and slow bit spacing.
   task automatic send_cell(input logic [31:0] h, input logic [7:0] e,
                            input logic [383:0] p);
      logic [423:0] c;
      c = {h, e, p};
      for (int i = 423; i >= 0; i--) begin
         @(posedge clk);
         rx_bit[0] <= c[i];
         @(posedge clk);
         rx_tgl[0] <= ~rx_tgl[0];
         repeat (3 + k % 3) @(posedge clk);
         k++;
      end
   endtask
endmodule

// file: test/testbench.sv
// Self-checking bench for the receive cell delineation block.
`timescale 1ns/1ps
module testbench;
   localparam logic [31:0] HDR = 32'h00000030;  // A user cell.
   logic        mclk, reset, cpu_wr, cpu_rd, cpu_rvalid;
   logic        out_hdr, out_valid, out_ready;
   logic [11:0] cpu_addr;
   logic [15:0] cpu_wdata, cpu_rdata, rx_bit, rx_tgl;
   logic [15:0] link_sync, lod, cnt_pulse, d;
   logic [31:0] out_data, link_state;
   logic [3:0]  out_link;
   logic [63:0] tx_len;
   integer      seed, n_fail, samples_checked, n_hdr, n_cnt, cyc, n_pay;
   logic [383:0] exp_pay;
   rcd_top rcd_top_inst (
      .MCLK(mclk), .RESET(reset), .CPU_ADDR(cpu_addr),
      .CPU_WDATA(cpu_wdata), .CPU_WR(cpu_wr), .CPU_RD(cpu_rd),
      .CPU_RDATA(cpu_rdata), .CPU_RVALID(cpu_rvalid), .RX_BIT(rx_bit),
      .RX_TGL(rx_tgl), .OUT_DATA(out_data), .OUT_LINK(out_link),
      .OUT_HDR(out_hdr), .OUT_VALID(out_valid), .OUT_READY(out_ready),
      .TX_FIFO_LEN(tx_len), .LINK_SYNC(link_sync),
      .LINK_STATE(link_state), .DELINEATION_LOSS_THRESHOLD(lod),
      .CELL_COUNT_PULSE(cnt_pulse));
   rcd_link_src rcd_link_src_inst (
      .clk(mclk), .rx_bit(rx_bit), .rx_tgl(rx_tgl));
   // ---------------------------------------------------------------
   // Tasks and functions
   // ---------------------------------------------------------------
   task automatic chk(input string nm, input logic [63:0] e,
                      input logic [63:0] g);
      samples_checked++;
      if (g !== e) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic end_sim;
      $display("Checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic wr(input logic [11:0] a, input logic [15:0] v);
      @(posedge mclk);
      cpu_addr <= a;
      cpu_wdata <= v;
      cpu_wr <= 1'b1;
      @(posedge mclk);
      cpu_wr <= 1'b0;
   endtask
   // Read answers exactly one cycle after the strobe, then drops.
   task automatic rdc(input logic [11:0] a, input logic [15:0] e);
      @(posedge mclk);
      cpu_addr <= a;
      cpu_rd <= 1'b1;
      @(posedge mclk);
      cpu_rd <= 1'b0;
      #1;
      chk("rvalid", 64'd1, cpu_rvalid);
      chk("rdata", e, cpu_rdata);
   endtask
   // Header check octet: CRC-8 over the header, then the coset.
   function automatic logic [7:0] hec(input logic [31:0] h);
      logic [7:0] c;
      c = 8'h00;
      for (int i = 31; i >= 0; i--) begin
         c = {c[6:0], 1'b0} ^ ((c[7] ^ h[i]) ? 8'h07 : 8'h00);
      end
      return c ^ 8'h55;
   endfunction
   task automatic send(input logic good, input logic rnd);
      logic [383:0] p;
      p = '0;
      for (int i = 0; i < 12; i++) begin
         if (rnd) p[32*i +: 32] = $random(seed);
      end
      if (rnd) exp_pay = p;
      rcd_link_src_inst.send_cell(HDR, good ? hec(HDR) : ~hec(HDR), p);
   endtask
   // Clock and a sink that stalls one cycle in four.
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      out_ready <= cyc[1:0] != 2'b00;
      if (!reset && cnt_pulse[0]) n_cnt++;
      if (!reset && out_valid && out_ready && out_hdr) begin
         n_hdr++;
         chk("hdr", HDR, out_data);
         chk("link", 64'd0, out_link);
      end
      // Descrambling is off on link 0, so payload words come out as sent.
      if (!reset && out_valid && out_ready && !out_hdr) begin
         chk("payload", exp_pay[352-32*n_pay +: 32], out_data);
         n_pay++;
      end
   end
   // Watchdog sized well past the expected run of about 23k cycles.
   initial begin
      repeat (60000) @(posedge mclk);
      n_fail++;
      end_sim;
   end
   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      seed = 32'h7eef;
      n_fail = 0;
      samples_checked = 0;
      n_hdr = 0;
      n_cnt = 0;
      n_pay = 0;
      exp_pay = '0;
      cyc = 0;
      reset = 1'b1;
      cpu_wr = 1'b0;
      cpu_rd = 1'b0;
      cpu_addr = 12'h000;
      cpu_wdata = 16'h0000;
      out_ready = 1'b0;
      repeat (5) @(posedge mclk);
      reset <= 1'b0;
      for (int i = 0; i < 8; i++) begin
         rdc(12'h08B + 12'(i), 16'h0101);
         rdc(12'h0C0 + 12'(i), 16'h0C0C);
      end
      rdc(12'h0C8, 16'h000C);
      rdc(12'h0C9, 16'h0067);
      rdc(12'h093, 16'h0000);
      rdc(12'h0CA, 16'h0000);
      for (int i = 0; i < 8; i++) begin
         d = 16'($random(seed));
         wr(12'h08B + 12'(i), d);
         wr(12'h0C0 + 12'(i), d);
         rdc(12'h08B + 12'(i), d & 16'h0FFF);
         rdc(12'h0C0 + 12'(i), d);
         chk("len_lo", d[3:0], tx_len[4*i +: 4]);
         chk("len_hi", d[11:8], tx_len[4*i+32 +: 4]);
      end
      d = 16'($random(seed)) | 16'h0001;
      wr(12'h0C8, d);
      rdc(12'h0C8, d & 16'h00FF);
      wr(12'h0C8, 16'h0001);
      wr(12'h0C9, 16'hA522);
      rdc(12'h0C9, 16'h0022);
      wr(12'h0C0, 16'h9C9C);
      // Hunt, two good headers to lock, two bad to fall back.
      send(1'b1, 1'b0);
      send(1'b1, 1'b0);
      chk("state", 2'b01, link_state[1:0]);
      send(1'b1, 1'b0);
      chk("state", 2'b10, link_state[1:0]);
      chk("sync", 64'd1, link_sync[0]);
      chk("lod", 64'd0, lod[0]);
      send(1'b1, 1'b1);
      send(1'b0, 1'b0);
      chk("state", 2'b10, link_state[1:0]);
      send(1'b0, 1'b0);
      chk("state", 2'b00, link_state[1:0]);
      // A dead line delivers zeros: an all-zero window never meets the
      // coset, so search cannot lock on a false header while loss builds.
      repeat (3) rcd_link_src_inst.send_cell(32'h0, 8'h00, 384'h0);
      chk("lod", 64'd1, lod[0]);
      chk("counted", 64'd1, n_cnt);
      chk("emitted", 64'd1, n_hdr);
      chk("words", 64'd12, n_pay);
      end_sim;
   end
endmodule
bind rcd_top rcd_checker rcd_checker_inst (
   .MCLK(MCLK), .RESET(RESET), .CPU_ADDR(CPU_ADDR),
   .CPU_WDATA(CPU_WDATA), .CPU_WR(CPU_WR), .CPU_RD(CPU_RD),
   .CPU_RDATA(CPU_RDATA), .TX_FIFO_LEN(TX_FIFO_LEN),
   .LINK_SYNC(LINK_SYNC), .LINK_STATE(LINK_STATE),
   .DELINEATION_LOSS_THRESHOLD(DELINEATION_LOSS_THRESHOLD),
   .CELL_COUNT_PULSE(CELL_COUNT_PULSE));
